// File: tpnvm_defines.vh
// constants for the table pointer and nonvolatile access block
`ifndef TPNVM_DEFINES_VH
`define TPNVM_DEFINES_VH
// widths
`define TPNVM_PTR_W 22
`define TPNVM_INC_W 21
`define TPNVM_HOLD_IDX_W 7
`define TPNVM_HOLD_DEPTH 128
// special function register selects
`define TPNVM_SEL_PTR_LOW 3'h0
`define TPNVM_SEL_PTR_HIGH 3'h1
`define TPNVM_SEL_PTR_UPPER 3'h2
`define TPNVM_SEL_LATCH 3'h3
`define TPNVM_SEL_CTRL 3'h4
`define TPNVM_SEL_KEY 3'h5
// control register fields
`define TPNVM_CTRL_REGION_HI 7
`define TPNVM_CTRL_REGION_LO 6
`define TPNVM_CTRL_FREE 4
`define TPNVM_CTRL_ERR 3
`define TPNVM_CTRL_WEN 2
`define TPNVM_CTRL_WR 1
// reset values
`define TPNVM_PTR_RST 8'h00
`define TPNVM_LATCH_RST 8'h00
`define TPNVM_CTRL_RST 8'h00
`define TPNVM_HOLD_RST 8'hff
// region select codes
`define TPNVM_REGION_PROG 2'h2
`define TPNVM_REGION_EE 2'h0
// unlock keys
`define TPNVM_KEY_FIRST 8'h55
`define TPNVM_KEY_SECOND 8'haa
// most clocks allowed between two unlock steps
`define TPNVM_KEY_GAP 3'h3
// table instruction forms
`define TPNVM_MODE_PLAIN 2'h0
`define TPNVM_MODE_POSTINC 2'h1
`define TPNVM_MODE_POSTDEC 2'h2
`define TPNVM_MODE_PREINC 2'h3
// address map, byte addresses
`define TPNVM_PROG_TOP 22'h01ffff
`define TPNVM_UID_BASE 22'h200000
`define TPNVM_UID_TOP 22'h20000f
`define TPNVM_CFG_BASE 22'h300000
`define TPNVM_CFG_TOP 22'h30000b
`define TPNVM_DID_BASE 22'h3ffffc
`define TPNVM_DID_TOP 22'h3fffff
`endif

// File: tpnvm_hold.v
// write holding register bank of 128 bytes
`timescale 1ns/1ps
`include "tpnvm_defines.vh"
module tpnvm_hold (
   // clock and reset
   input wire clk_sys_in,
   input wire nrst_in,
   // byte load from the table latch
   input wire load_in,
   input wire [`TPNVM_HOLD_IDX_W-1:0] load_idx_in,
   input wire [7:0] load_data_in,
   // return to erased value after a block write
   input wire clear_in,
   // read side for the flash programmer
   input wire [`TPNVM_HOLD_IDX_W-1:0] rd_idx_in,
   output reg [7:0] rd_data_out
);
   reg [7:0] mem_q [0:`TPNVM_HOLD_DEPTH-1];
   integer i;

   always @(posedge clk_sys_in) begin
      if (!nrst_in || clear_in) begin
         for (i = 0; i < `TPNVM_HOLD_DEPTH; i = i + 1) begin
            mem_q[i] <= `TPNVM_HOLD_RST;
         end
      end else if (load_in) begin
         mem_q[load_idx_in] <= load_data_in;
      end
   end

   // registered so the programmer sees flop data one clock after the index
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         rd_data_out <= `TPNVM_HOLD_RST;
      end else begin
         rd_data_out <= mem_q[rd_idx_in];
      end
   end
endmodule // tpnvm_hold

// File: tpnvm_access.v
// table pointer, byte latch, unlock guard and stall control
// Notes on behaviour
// - three pointer bytes form one 22-bit address
// - bits 0-20 program space, bit 21 id/config
// - auto adjust touches bits 0-20 only
// - plain form leaves pointer unchanged
// - post-increment: transfer, then add one
// - post-decrement: transfer, then subtract one
// - pre-increment: add one, then transfer
// - 8-bit latch in register space
// - read uses all 22 bits into latch
// - write loads holding byte by low bits
// - block write uses upper pointer bits only
// - byte transfers, no alignment needed
// - read stalls cpu briefly, latch valid after
// - address bit 0 picks word byte
// - long operations rejected without full unlock
// - unlock: 55h, aah, then set start bit
// - started operation stalls cpu until finished
// - region select picks write target
// - unimplemented reads zero, writes flag error
// - erase done clears start, signals completion
// - unlock steps at most three idle clocks apart, disturbance aborts
`timescale 1ns/1ps
`include "tpnvm_defines.vh"
module tpnvm_access (
   // clock and reset
   input wire clk_sys_in,
   input wire nrst_in,
   // special function register port
   input wire sfr_wr_in,
   input wire sfr_rd_in,
   input wire [2:0] sfr_sel_in,
   input wire [7:0] sfr_wdata_in,
   output reg [7:0] sfr_rdata_out,
   // table instruction request from the core
   input wire tbl_req_in,
   input wire tbl_write_in,
   input wire [1:0] tbl_mode_in,
   output reg tbl_done_out,
   output wire cpu_stall_out,
   // events that disturb the unlock timing
   input wire irq_entry_in,
   input wire debug_halt_in,
   // program memory read port
   output reg flash_rd_en_out,
   output reg [`TPNVM_PTR_W-2:0] flash_rd_word_addr_out,
   input wire flash_rd_ack_in,
   input wire [15:0] flash_rd_word_in,
   // long operation port
   output reg flash_op_req_out,
   output reg flash_op_erase_out,
   output reg [1:0] flash_op_target_out,
   output reg [`TPNVM_PTR_W-1:0] flash_op_row_addr_out,
   input wire flash_op_done_in,
   input wire flash_op_fail_in,
   input wire [`TPNVM_HOLD_IDX_W-1:0] hold_rd_idx_in,
   output wire [7:0] hold_rd_data_out,
   // completion event toward the interrupt flag
   output reg nv_done_pulse_out
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_READ = 2'h1;
   localparam [1:0] ST_OP = 2'h2;
   localparam [1:0] KEY_NONE = 2'h0;
   localparam [1:0] KEY_ONE = 2'h1;
   localparam [1:0] KEY_TWO = 2'h2;

   reg [1:0] state_q, state_d;
   reg [7:0] ptr_upper_q, ptr_upper_d;
   reg [7:0] ptr_high_q, ptr_high_d;
   reg [7:0] ptr_low_q, ptr_low_d;
   reg [7:0] latch_q, latch_d;
   reg [1:0] region_q, region_d;
   reg free_q, free_d;
   reg err_q, err_d;
   reg wen_q, wen_d;
   reg wr_q, wr_d;
   reg [1:0] key_q, key_d;
   reg [2:0] gap_q, gap_d;
   reg [1:0] rd_mode_q, rd_mode_d;
   reg hold_load;
   reg hold_clear;
   reg done_d;
   reg rd_en_d;
   reg [`TPNVM_PTR_W-2:0] rd_addr_d;
   reg op_start;
   reg [`TPNVM_PTR_W-1:0] ptr_next;
   reg [`TPNVM_PTR_W-1:0] xfer_addr;
   reg other_access;
   wire [`TPNVM_PTR_W-1:0] table_address_pointer;
   wire [`TPNVM_PTR_W-1:0] ptr_inc;
   wire [`TPNVM_PTR_W-1:0] ptr_dec;

   assign table_address_pointer = {ptr_upper_q[5:0], ptr_high_q, ptr_low_q};
   // bit 21 is carried untouched, the 21-bit field wraps on its own
   assign ptr_inc = {table_address_pointer[21],
                     table_address_pointer[20:0] + 21'h000001};
   assign ptr_dec = {table_address_pointer[21],
                     table_address_pointer[20:0] - 21'h000001};
   assign cpu_stall_out = (state_q != ST_IDLE);

   // regions that a table read may reach
   function rd_mapped;
      input [`TPNVM_PTR_W-1:0] a;
      begin
         rd_mapped = (a <= `TPNVM_PROG_TOP) ||
                     (a >= `TPNVM_UID_BASE && a <= `TPNVM_UID_TOP) ||
                     (a >= `TPNVM_CFG_BASE && a <= `TPNVM_CFG_TOP) ||
                     (a >= `TPNVM_DID_BASE);
      end
   endfunction

   // targets that a long operation may reach for a region select
   function wr_mapped;
      input [1:0] region;
      input [`TPNVM_PTR_W-1:0] a;
      begin
         if (region[0]) begin
            // device identification words are read only
            wr_mapped = (a >= `TPNVM_UID_BASE && a <= `TPNVM_UID_TOP) ||
                        (a >= `TPNVM_CFG_BASE && a <= `TPNVM_CFG_TOP);
         end else if (region == `TPNVM_REGION_PROG) begin
            wr_mapped = (a <= `TPNVM_PROG_TOP);
         end else begin
            // data eeprom takes its address elsewhere
            wr_mapped = 1'b1;
         end
      end
   endfunction

   always @* begin
      state_d = state_q;
      ptr_upper_d = ptr_upper_q;
      ptr_high_d = ptr_high_q;
      ptr_low_d = ptr_low_q;
      latch_d = latch_q;
      region_d = region_q;
      free_d = free_q;
      err_d = err_q;
      wen_d = wen_q;
      wr_d = wr_q;
      key_d = key_q;
      gap_d = gap_q;
      rd_mode_d = rd_mode_q;
      hold_load = 1'b0;
      hold_clear = 1'b0;
      done_d = 1'b0;
      rd_en_d = 1'b0;
      rd_addr_d = flash_rd_word_addr_out;
      op_start = 1'b0;
      ptr_next = table_address_pointer;
      xfer_addr = table_address_pointer;
      other_access = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (tbl_req_in) begin
               other_access = 1'b1;
               if (tbl_mode_in == `TPNVM_MODE_PREINC) begin
                  xfer_addr = ptr_inc;
               end
               case (tbl_mode_in)
                  `TPNVM_MODE_POSTINC: ptr_next = ptr_inc;
                  `TPNVM_MODE_POSTDEC: ptr_next = ptr_dec;
                  `TPNVM_MODE_PREINC: ptr_next = ptr_inc;
                  default: ptr_next = table_address_pointer;
               endcase
               if (tbl_write_in) begin
                  // only the low bits matter, flash is not touched
                  hold_load = 1'b1;
                  done_d = 1'b1;
               end else if (rd_mapped(xfer_addr)) begin
                  rd_en_d = 1'b1;
                  rd_addr_d = xfer_addr[21:1];
                  rd_mode_d = {1'b0, xfer_addr[0]};
                  state_d = ST_READ;
               end else begin
                  latch_d = 8'h00;
                  done_d = 1'b1;
               end
               // pre-increment already moved the transfer address, every form writes the pointer now
               ptr_upper_d = {2'b00, ptr_next[21:16]};
               ptr_high_d = ptr_next[15:8];
               ptr_low_d = ptr_next[7:0];
            end else if (sfr_wr_in) begin
               case (sfr_sel_in)
                  `TPNVM_SEL_PTR_LOW: ptr_low_d = sfr_wdata_in;
                  `TPNVM_SEL_PTR_HIGH: ptr_high_d = sfr_wdata_in;
                  `TPNVM_SEL_PTR_UPPER: ptr_upper_d = {2'b00, sfr_wdata_in[5:0]};
                  `TPNVM_SEL_LATCH: latch_d = sfr_wdata_in;
                  `TPNVM_SEL_CTRL: begin
                     region_d = sfr_wdata_in[`TPNVM_CTRL_REGION_HI:`TPNVM_CTRL_REGION_LO];
                     free_d = sfr_wdata_in[`TPNVM_CTRL_FREE];
                     wen_d = sfr_wdata_in[`TPNVM_CTRL_WEN];
                     err_d = sfr_wdata_in[`TPNVM_CTRL_ERR];
                     if (sfr_wdata_in[`TPNVM_CTRL_WR] && key_q == KEY_TWO && wen_d) begin
                        if (wr_mapped(region_d, table_address_pointer)) begin
                           wr_d = 1'b1;
                           op_start = 1'b1;
                           state_d = ST_OP;
                        end else begin
                           err_d = 1'b1;
                           wr_d = 1'b0;
                        end
                     end
                     // without a full unlock the start bit is simply not taken
                     key_d = KEY_NONE;
                  end
                  `TPNVM_SEL_KEY: begin
                     if (key_q == KEY_NONE && sfr_wdata_in == `TPNVM_KEY_FIRST) begin
                        key_d = KEY_ONE;
                     end else if (key_q == KEY_ONE && sfr_wdata_in == `TPNVM_KEY_SECOND) begin
                        key_d = KEY_TWO;
                     end else if (sfr_wdata_in == `TPNVM_KEY_FIRST) begin
                        key_d = KEY_ONE;
                     end else begin
                        key_d = KEY_NONE;
                     end
                     gap_d = 3'h0;
                  end
                  default: other_access = 1'b1;
               endcase
               if (sfr_sel_in != `TPNVM_SEL_KEY && sfr_sel_in != `TPNVM_SEL_CTRL) begin
                  other_access = 1'b1;
               end
            end else if (sfr_rd_in) begin
               other_access = 1'b1;
            end
            // the sequence may idle up to three clocks between steps; slower steps abort it
            if (key_q != KEY_NONE && !(sfr_wr_in && sfr_sel_in == `TPNVM_SEL_KEY)) begin
               gap_d = gap_q + 3'h1;
               if (gap_q == `TPNVM_KEY_GAP) begin
                  key_d = KEY_NONE;
               end
            end
            if (other_access || irq_entry_in || debug_halt_in) begin
               key_d = KEY_NONE;
            end
         end
         ST_READ: begin
            if (flash_rd_ack_in) begin
               latch_d = rd_mode_q[0] ? flash_rd_word_in[15:8] : flash_rd_word_in[7:0];
               done_d = 1'b1;
               state_d = ST_IDLE;
            end
         end
         ST_OP: begin
            if (flash_op_done_in || flash_op_fail_in) begin
               wr_d = 1'b0;
               done_d = 1'b1;
               state_d = ST_IDLE;
               if (flash_op_fail_in) begin
                  err_d = 1'b1;
               end
               // holding bytes return to erased value after a block write
               if (flash_op_done_in && !flash_op_erase_out &&
                   flash_op_target_out != `TPNVM_REGION_EE) begin
                  hold_clear = 1'b1;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         state_q <= ST_IDLE;
         ptr_upper_q <= `TPNVM_PTR_RST;
         ptr_high_q <= `TPNVM_PTR_RST;
         ptr_low_q <= `TPNVM_PTR_RST;
         latch_q <= `TPNVM_LATCH_RST;
         region_q <= 2'h0;
         free_q <= 1'b0;
         err_q <= 1'b0;
         wen_q <= 1'b0;
         wr_q <= 1'b0;
         key_q <= KEY_NONE;
         gap_q <= 3'h0;
         rd_mode_q <= 2'h0;
         tbl_done_out <= 1'b0;
         flash_rd_en_out <= 1'b0;
         flash_rd_word_addr_out <= 21'h000000;
         flash_op_req_out <= 1'b0;
         flash_op_erase_out <= 1'b0;
         flash_op_target_out <= 2'h0;
         flash_op_row_addr_out <= 22'h000000;
         nv_done_pulse_out <= 1'b0;
      end else begin
         state_q <= state_d;
         ptr_upper_q <= ptr_upper_d;
         ptr_high_q <= ptr_high_d;
         ptr_low_q <= ptr_low_d;
         latch_q <= latch_d;
         region_q <= region_d;
         free_q <= free_d;
         err_q <= err_d;
         wen_q <= wen_d;
         wr_q <= wr_d;
         key_q <= key_d;
         gap_q <= gap_d;
         rd_mode_q <= rd_mode_d;
         tbl_done_out <= done_d && (state_q != ST_OP);
         flash_rd_en_out <= rd_en_d;
         flash_rd_word_addr_out <= rd_addr_d;
         if (op_start) begin
            flash_op_req_out <= 1'b1;
            flash_op_erase_out <= free_d;
            flash_op_target_out <= region_d;
            // block base: low holding index bits are masked
            flash_op_row_addr_out <= {table_address_pointer[21:`TPNVM_HOLD_IDX_W],
                                      7'h00};
         end else if (state_q == ST_OP && state_d == ST_IDLE) begin
            flash_op_req_out <= 1'b0;
         end
         nv_done_pulse_out <= (state_q == ST_OP) && flash_op_done_in;
      end
   end

   // register reads answer one clock after the strobe
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_rd_in) begin
         case (sfr_sel_in)
            `TPNVM_SEL_PTR_LOW: sfr_rdata_out <= ptr_low_q;
            `TPNVM_SEL_PTR_HIGH: sfr_rdata_out <= ptr_high_q;
            `TPNVM_SEL_PTR_UPPER: sfr_rdata_out <= ptr_upper_q;
            `TPNVM_SEL_LATCH: sfr_rdata_out <= latch_q;
            `TPNVM_SEL_CTRL: sfr_rdata_out <= {region_q, 1'b0, free_q, err_q, wen_q, wr_q, 1'b0};
            default: sfr_rdata_out <= 8'h00;
         endcase
      end
   end

   tpnvm_hold u_hold (
      .clk_sys_in(clk_sys_in),
      .nrst_in(nrst_in),
      .load_in(hold_load),
      .load_idx_in(xfer_addr[`TPNVM_HOLD_IDX_W-1:0]),
      .load_data_in(latch_q),
      .clear_in(hold_clear),
      .rd_idx_in(hold_rd_idx_in),
      .rd_data_out(hold_rd_data_out)
   );
endmodule // tpnvm_access

// File: tpnvm_flash_model.sv
// program memory and long operation responder for the access bench
`timescale 1ns/1ps
module tpnvm_flash_model #(
   parameter [3:0] OP_LAT = 4'h6
) (
   // clock and reset
   input wire clk_sys_in,
   input wire nrst_in,
   // word read port
   input wire rd_en_in,
   input wire [20:0] rd_addr_in,
   output reg rd_ack_out,
   output reg [15:0] rd_word_out,
   // long operation port
   input wire op_req_in,
   output reg op_done_out
);
   reg [20:0] addr_q;
   reg [2:0] rd_cnt_q;
   reg slow_q;
   reg busy_q;
   reg [3:0] op_cnt_q;
   always @(posedge clk_sys_in) begin
      rd_ack_out <= 1'b0;
      op_done_out <= 1'b0;
      // outside an answer or reset the bus inverts every clock, so no word stays stable on it
      rd_word_out <= ~rd_word_out;
      if (!nrst_in) begin
         rd_cnt_q <= 3'h0;
         slow_q <= 1'b0;
         busy_q <= 1'b0;
         op_cnt_q <= 4'h0;
         rd_word_out <= 16'h0000;
      end else begin
         if (rd_en_in) begin
            addr_q <= rd_addr_in;
            // alternate prompt and slow answers
            rd_cnt_q <= slow_q ? 3'h5 : 3'h1;
            slow_q <= ~slow_q;
         end else if (rd_cnt_q != 3'h0) begin
            rd_cnt_q <= rd_cnt_q - 3'h1;
            if (rd_cnt_q == 3'h1) begin
               rd_ack_out <= 1'b1;
               rd_word_out <= {addr_q[7:0] ^ 8'h3c, addr_q[7:0]};
            end
         end
         if (!op_req_in) begin
            busy_q <= 1'b0;
         end else if (!busy_q) begin
            busy_q <= 1'b1;
            op_cnt_q <= OP_LAT;
         end else if (op_cnt_q != 4'h0) begin
            op_cnt_q <= op_cnt_q - 4'h1;
            op_done_out <= (op_cnt_q == 4'h1);
         end
      end
   end
endmodule  // tpnvm_flash_model

// File: tpnvm_access_assertions.sv
// port checks on the table access and unlock block
`timescale 1ns/1ps
`include "tpnvm_defines.vh"
module tpnvm_access_assertions (
   // clock and reset
   input wire clk_sys_in,
   input wire nrst_in,
   // requests
   input wire sfr_wr_in,
   input wire sfr_rd_in,
   input wire [2:0] sfr_sel_in,
   input wire [7:0] sfr_wdata_in,
   input wire tbl_req_in,
   input wire irq_entry_in,
   input wire debug_halt_in,
   // answers
   input wire tbl_done_out,
   input wire cpu_stall_out,
   input wire flash_rd_ack_in,
   input wire flash_op_req_out,
   input wire [`TPNVM_PTR_W-1:0] flash_op_row_addr_out,
   input wire flash_op_done_in,
   input wire flash_op_fail_in,
   input wire nv_done_pulse_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   reg start_wr_q;
   always @(posedge clk_sys_in) begin
      start_wr_q <= sfr_wr_in && sfr_sel_in == `TPNVM_SEL_CTRL && sfr_wdata_in[`TPNVM_CTRL_WR];
   end
   sequence key_first;
      sfr_wr_in && sfr_sel_in == `TPNVM_SEL_KEY && sfr_wdata_in == `TPNVM_KEY_FIRST && !cpu_stall_out;
   endsequence
   sequence gap;
      !sfr_wr_in && !sfr_rd_in && !tbl_req_in && !irq_entry_in && !debug_halt_in;
   endsequence
   sequence key_second;
      sfr_wr_in && sfr_sel_in == `TPNVM_SEL_KEY && sfr_wdata_in == `TPNVM_KEY_SECOND && !irq_entry_in;
   endsequence
   sequence start_go;
      sfr_wr_in && sfr_sel_in == `TPNVM_SEL_CTRL && sfr_wdata_in[2:1] == 2'b11 && !irq_entry_in && !debug_halt_in;
   endsequence
   AST_UNLOCK_RUNS: assert property (key_first ##1 gap ##1 key_second ##1 gap ##1 start_go ##0
      sfr_wdata_in[7:6] == `TPNVM_REGION_EE |=> flash_op_req_out && cpu_stall_out) else $error("unlock ignored");
   AST_DISTURB: assert property (key_first ##1 (irq_entry_in || debug_halt_in) ##1 key_second
      ##1 gap ##1 start_go |=> !flash_op_req_out) else $error("disturbed unlock ran");
   AST_BAD_KEY: assert property (key_first ##1 gap ##1 (sfr_wr_in && sfr_sel_in == `TPNVM_SEL_KEY &&
      sfr_wdata_in == 8'h00) ##1 gap ##1 start_go |=> !flash_op_req_out) else $error("broken unlock ran");
   AST_START_CAUSE: assert property ($rose(flash_op_req_out) |-> start_wr_q)
      else $error("operation without start write");
   AST_OP_HOLD: assert property (flash_op_req_out && !flash_op_done_in && !flash_op_fail_in
      |=> flash_op_req_out && cpu_stall_out) else $error("stall dropped early");
   AST_OP_END: assert property (flash_op_req_out && flash_op_done_in
      |=> !flash_op_req_out && !cpu_stall_out && nv_done_pulse_out) else $error("bad completion");
   AST_ROW_ALIGN: assert property (flash_op_req_out |-> flash_op_row_addr_out[6:0] == 7'h00)
      else $error("row address not aligned");
   AST_READ_DONE: assert property (cpu_stall_out && !flash_op_req_out && flash_rd_ack_in
      |=> tbl_done_out && !cpu_stall_out) else $error("read not finished");
endmodule  // tpnvm_access_assertions
bind tpnvm_access tpnvm_access_assertions u_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
   .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_sel_in(sfr_sel_in), .sfr_wdata_in(sfr_wdata_in),
   .tbl_req_in(tbl_req_in), .irq_entry_in(irq_entry_in), .debug_halt_in(debug_halt_in),
   .tbl_done_out(tbl_done_out), .cpu_stall_out(cpu_stall_out), .flash_rd_ack_in(flash_rd_ack_in),
   .flash_op_req_out(flash_op_req_out), .flash_op_row_addr_out(flash_op_row_addr_out),
   .flash_op_done_in(flash_op_done_in), .flash_op_fail_in(flash_op_fail_in), .nv_done_pulse_out(nv_done_pulse_out));

// File: tpnvm_access_test.sv
// self-checking bench for the table access and unlock block
`timescale 1ns/1ps
`include "tpnvm_defines.vh"
module tpnvm_access_test;
   reg clk_sys_in = 1'b0;
   reg nrst_in = 1'b0;
   reg sfr_wr_in = 1'b0, sfr_rd_in = 1'b0, tbl_req_in = 1'b0, tbl_write_in = 1'b0, pend = 1'b0, pend_d = 1'b0;
   reg irq_entry_in = 1'b0, debug_halt_in = 1'b0, dirq = 1'b0, dhalt = 1'b0;
   reg [2:0] sfr_sel_in = 3'h0;
   reg [7:0] sfr_wdata_in = 8'h00, d;
   reg [1:0] tbl_mode_in = 2'h0;
   reg [6:0] hold_rd_idx_in = 7'h00;
   reg [21:0] ptr, xa, p;
   reg [8:0] exp_q[$];
   reg [8:0] e;
   integer n_mismatch = 0, compares = 0, i, k;
   wire [7:0] sfr_rdata_out, hold_rd_data_out;
   wire [20:0] rd_addr;
   wire [15:0] rd_word;
   wire tbl_done_out, cpu_stall_out, rd_en, rd_ack, op_req, op_done;
   always #2.5 clk_sys_in = ~clk_sys_in;
   tpnvm_access uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
      .sfr_sel_in(sfr_sel_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out), .tbl_req_in(tbl_req_in),
      .tbl_write_in(tbl_write_in), .tbl_mode_in(tbl_mode_in), .tbl_done_out(tbl_done_out),
      .cpu_stall_out(cpu_stall_out), .irq_entry_in(irq_entry_in), .debug_halt_in(debug_halt_in),
      .flash_rd_en_out(rd_en), .flash_rd_word_addr_out(rd_addr), .flash_rd_ack_in(rd_ack),
      .flash_rd_word_in(rd_word), .flash_op_req_out(op_req), .flash_op_erase_out(), .flash_op_target_out(),
      .flash_op_row_addr_out(), .flash_op_done_in(op_done), .flash_op_fail_in(1'b0),
      .hold_rd_idx_in(hold_rd_idx_in), .hold_rd_data_out(hold_rd_data_out), .nv_done_pulse_out());
   tpnvm_flash_model model (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
      .rd_ack_out(rd_ack), .rd_word_out(rd_word), .op_req_in(op_req), .op_done_out(op_done));
   // results show one cycle after the strobe
   always @(posedge clk_sys_in) begin
      pend_d <= pend;
      if (pend_d) begin
         e = exp_q.pop_front();
         compares = compares + 1;
         if ((e[8] ? hold_rd_data_out : sfr_rdata_out) !== e[7:0]) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: got %h/%h expected %h", $time, sfr_rdata_out, hold_rd_data_out, e[7:0]);
         end
      end
   end
   task fail(input string m);
      begin
         n_mismatch = n_mismatch + 1;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task end_of_test;
      begin
         $display("compares %0d mismatches %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   function [21:0] step(input [21:0] a, input [20:0] dl);
      step = {a[21], a[20:0] + dl};
   endfunction
   function [7:0] byte_at(input [21:0] a);
      if (a <= `TPNVM_PROG_TOP || (a >= `TPNVM_UID_BASE && a <= `TPNVM_UID_TOP) ||
         (a >= `TPNVM_CFG_BASE && a <= `TPNVM_CFG_TOP) || a >= `TPNVM_DID_BASE)
         byte_at = a[0] ? a[8:1] ^ 8'h3c : a[8:1];
      else
         byte_at = 8'h00;
   endfunction
   // disturbance, if asked, lands in the gap after the strobe
   task sfr(input w, input r, input [2:0] s, input [7:0] v);
      begin
         @(posedge clk_sys_in);
         sfr_wr_in <= w;
         sfr_rd_in <= r;
         pend <= r;
         sfr_sel_in <= s;
         sfr_wdata_in <= v;
         irq_entry_in <= 1'b0;
         debug_halt_in <= 1'b0;
         @(posedge clk_sys_in);
         sfr_wr_in <= 1'b0;
         sfr_rd_in <= 1'b0;
         pend <= 1'b0;
         sfr_wdata_in <= 8'($urandom);
         irq_entry_in <= dirq;
         debug_halt_in <= dhalt;
      end
   endtask
   task rd(input [2:0] s, input [7:0] v);
      begin
         exp_q.push_back({1'b0, v});
         sfr(1'b0, 1'b1, s, 8'h00);
      end
   endtask
   task hchk(input [6:0] idx, input [7:0] v);
      begin
         exp_q.push_back({1'b1, v});
         @(posedge clk_sys_in);
         hold_rd_idx_in <= idx;
         pend <= 1'b1;
         @(posedge clk_sys_in);
         pend <= 1'b0;
      end
   endtask
   task setp(input [21:0] a);
      begin
         ptr = a;
         sfr(1'b1, 1'b0, `TPNVM_SEL_PTR_LOW, a[7:0]);
         sfr(1'b1, 1'b0, `TPNVM_SEL_PTR_HIGH, a[15:8]);
         sfr(1'b1, 1'b0, `TPNVM_SEL_PTR_UPPER, {2'b00, a[21:16]});
      end
   endtask
   task chkp;
      begin
         rd(`TPNVM_SEL_PTR_LOW, ptr[7:0]);
         rd(`TPNVM_SEL_PTR_HIGH, ptr[15:8]);
         rd(`TPNVM_SEL_PTR_UPPER, {2'b00, ptr[21:16]});
      end
   endtask
   task tbl(input w, input [1:0] m);
      begin
         @(posedge clk_sys_in);
         tbl_req_in <= 1'b1;
         tbl_write_in <= w;
         tbl_mode_in <= m;
         @(posedge clk_sys_in);
         tbl_req_in <= 1'b0;
         i = 0;
         while (tbl_done_out !== 1'b1 && i < 40) begin
            @(posedge clk_sys_in);
            i = i + 1;
         end
         if (i == 40) fail("table op hung");
      end
   endtask
   task tread(input [21:0] a, input [1:0] m);
      begin
         setp(a);
         tbl(1'b0, m);
         xa = (m == `TPNVM_MODE_PREINC) ? step(a, 21'h000001) : a;
         ptr = (m == `TPNVM_MODE_PLAIN) ? a : step(a, (m == `TPNVM_MODE_POSTDEC) ? 21'h1fffff : 21'h000001);
         rd(`TPNVM_SEL_LATCH, byte_at(xa));
         chkp;
      end
   endtask
   // interrupts stay quiet around the keys unless a disturbance is wanted
   task unlock(input [7:0] k2, input [7:0] c, input di, input dh);
      begin
         dirq = di;
         dhalt = dh;
         sfr(1'b1, 1'b0, `TPNVM_SEL_KEY, `TPNVM_KEY_FIRST);
         dirq = 1'b0;
         dhalt = 1'b0;
         sfr(1'b1, 1'b0, `TPNVM_SEL_KEY, k2);
         sfr(1'b1, 1'b0, `TPNVM_SEL_CTRL, c);
         i = 0;
         @(posedge clk_sys_in);
         while (cpu_stall_out !== 1'b0 && i < 60) begin
            @(posedge clk_sys_in);
            i = i + 1;
         end
         if (i == 60) fail("long op hung");
      end
   endtask
   initial begin
      #200000;
      fail("timeout");
      end_of_test;
   end
   initial begin
      d = 8'($urandom(32'h4a1dc290));
      repeat (4) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      for (k = 0; k < 8; k = k + 1)
         rd(k[2:0], 8'h00);
      hchk(7'h00, 8'hff);
      $display("reset value test done");
      for (k = 0; k < 4; k = k + 1)
         tread({5'h00, 17'($urandom)}, k[1:0]);
      tread(22'h3fffff, `TPNVM_MODE_POSTINC);
      tread(22'h200000, `TPNVM_MODE_POSTDEC);
      tread(22'h1fffff, `TPNVM_MODE_PREINC);
      tread(22'h30000c, `TPNVM_MODE_PLAIN);
      $display("table read test done");
      d = 8'($urandom);
      sfr(1'b1, 1'b0, `TPNVM_SEL_LATCH, d);
      p = {6'h00, 16'($urandom)};
      setp(p);
      tbl(1'b1, `TPNVM_MODE_POSTINC);
      ptr = step(p, 21'h000001);
      chkp;
      rd(`TPNVM_SEL_LATCH, d);
      hchk(p[6:0], d);
      unlock(8'haa, 8'h96, 1'b0, 1'b0);
      rd(`TPNVM_SEL_CTRL, 8'h94);
      hchk(p[6:0], d);
      unlock(8'haa, 8'h86, 1'b0, 1'b0);
      hchk(p[6:0], 8'hff);
      $display("erase and write test done");
      tbl(1'b1, `TPNVM_MODE_PLAIN);
      unlock(8'h00, 8'h86, 1'b0, 1'b0);
      unlock(8'haa, 8'h86, 1'b1, 1'b0);
      unlock(8'haa, 8'h86, 1'b0, 1'b1);
      rd(`TPNVM_SEL_CTRL, 8'h84);
      hchk(ptr[6:0], d);
      unlock(8'haa, 8'h06, 1'b0, 1'b0);
      rd(`TPNVM_SEL_CTRL, 8'h04);
      setp(22'h200000);
      unlock(8'haa, 8'hc6, 1'b0, 1'b0);
      setp(22'h300000);
      unlock(8'haa, 8'h46, 1'b0, 1'b0);
      rd(`TPNVM_SEL_CTRL, 8'h44);
      setp(22'h250000);
      unlock(8'haa, 8'h46, 1'b0, 1'b0);
      rd(`TPNVM_SEL_CTRL, 8'h4c);
      $display("unlock test done");
      repeat (3) @(posedge clk_sys_in);
      end_of_test;
   end
endmodule  // tpnvm_access_test
